// file: rtl/sdc_params.svh
// Behaviour
// [R1] sample every pin on rising clock edge
// [R2] each edge steps burst column and outputs
// [R3] clock enable low: power-down, self refresh, suspend
// [R4] clock enable stays watched during power-down
// [R5] power-down and self refresh freeze input receivers
// [R6] chip select high masks every command
// [R7] running bursts and byte masks survive deselect
// [R8] command code from select and three strobes
// [R9] write byte dropped where mask high
// [R10] read byte high impedance two clocks later
// [R11] mask n governs data byte lane n
// [R12] bank select picks the addressed bank
// [R13] mode load stores bank and address bits
// [R14] activate opens twelve-bit row
// [R15] eight-bit start column, bit ten auto precharge
// [R16] precharge: bit ten all, else one bank
// [R17] clock enable may be tied high
// [R18] column commands ignore upper address bits
`ifndef SDC_PARAMS_SVH
`define SDC_PARAMS_SVH
`define SDC_ROW_W 12
`define SDC_COL_W 8
`define SDC_BL_W 9
`define SDC_AP_BIT 10
`define SDC_OP_LMR 3'h0
`define SDC_OP_REF 3'h1
`define SDC_OP_PRE 3'h2
`define SDC_OP_ACT 3'h3
`define SDC_OP_WR 3'h4
`define SDC_OP_RD 3'h5
`define SDC_OP_BST 3'h6
`define SDC_STROBES_IDLE 4'hF
`define SDC_ONE_BANK 4'h1
`define SDC_LAST_BEAT 9'h001
`define SDC_COL_STEP 8'h01
`endif

// file: rtl/sdc_pkg.sv
`default_nettype none
package sdc_pkg;
  typedef enum logic [2:0] {
    PWR_RUN, PWR_SUSPEND, PWR_ACT_DOWN, PWR_PRE_DOWN, PWR_SELF_REF
  } sdc_pwr_e;
  typedef enum logic [3:0] {
    CMD_INHIBIT, CMD_NOP, CMD_ACT, CMD_READ, CMD_WRITE, CMD_BST, CMD_PRE, CMD_REF, CMD_LMR
  } sdc_cmd_e;
endpackage
`default_nettype wire

// file: rtl/sdc_pin_if.sv
`default_nettype none
`include "sdc_params.svh"
module sdc_pin_if (
  input  wire logic                    core_clk,
  input  wire logic                    rst_n,
  input  wire logic                    cke,
  input  wire logic                    csN,
  input  wire logic                    rasN,
  input  wire logic                    casN,
  input  wire logic                    weN,
  input  wire logic [3:0]              byteMask,
  input  wire logic [1:0]              bankSelect,
  input  wire logic [`SDC_ROW_W-1:0]   addressIn,
  input  wire logic [31:0]             dataIn,
  output logic      [31:0]             dataOut,
  output logic      [31:0]             dataOe,
  input  wire logic [`SDC_BL_W-1:0]    burstLength,
  input  wire logic [31:0]             arrayRdData,
  output logic                         rxEnable,
  output sdc_pkg::sdc_pwr_e            powerState,
  output logic      [3:0]              bankOpen,
  output logic                         actValid,
  output logic      [1:0]              actBank,
  output logic      [`SDC_ROW_W-1:0]   actRow,
  output logic                         refValid,
  output logic                         lmrValid,
  output logic      [`SDC_ROW_W+1:0]   modeOpcode,
  output logic                         arrRdEn,
  output logic                         arrWrEn,
  output logic      [1:0]              arrBank,
  output logic      [`SDC_COL_W-1:0]   arrCol,
  output logic      [31:0]             arrWrData,
  output logic      [3:0]              arrWrByteEn
);
  localparam int PIN_W = 55;
  localparam logic [PIN_W-1:0] PIN_RST = {1'b0, `SDC_STROBES_IDLE, {(PIN_W-5){1'b0}}};

  logic [PIN_W-1:0]        pinMeta_q, pinSync_q, pinSync_d;
  logic                    ckeS, csS, rasS, casS, weS;
  logic [3:0]              maskS;
  logic [1:0]              bankS;
  logic [`SDC_ROW_W-1:0]   addrS;
  logic [31:0]             dataS;
  sdc_pkg::sdc_cmd_e       cmdRaw, cmdLive;
  sdc_pkg::sdc_pwr_e       state_q, state_d;
  logic                    live, susp, startRW, beat, beatWr, beatAp;
  logic [1:0]              beatBank;
  logic [`SDC_COL_W-1:0]   beatCol;
  logic [`SDC_BL_W-1:0]    beatLeft;
  logic [3:0]              bankDec;
  logic [3:0]              bankOpen_q, bankOpen_d;
  logic                    burstAct_q, burstAct_d, burstWr_q, burstWr_d, burstAp_q, burstAp_d;
  logic [1:0]              burstBank_q, burstBank_d;
  logic [`SDC_COL_W-1:0]   burstCol_q, burstCol_d;
  logic [`SDC_BL_W-1:0]    burstLeft_q, burstLeft_d;
  logic                    actValid_d, refValid_d, lmrValid_d, arrRdEn_d, arrWrEn_d;
  logic [1:0]              actBank_d, arrBank_d;
  logic [`SDC_ROW_W-1:0]   actRow_d;
  logic [`SDC_ROW_W+1:0]   modeOpcode_d;
  logic [`SDC_COL_W-1:0]   arrCol_d;
  logic [31:0]             arrWrData_d, dataOut_d;
  logic [3:0]              arrWrByteEn_d, maskD1_q, maskD1_d, oe_q, oe_d;

  assign {ckeS, csS, rasS, casS, weS, maskS, bankS, addrS, dataS} = pinSync_q;
  assign powerState = state_q;
  assign live       = state_q == sdc_pkg::PWR_RUN;
  assign susp       = state_q == sdc_pkg::PWR_SUSPEND;
  assign rxEnable   = live || susp;
  assign bankOpen   = bankOpen_q;

  // receivers off in power-down: only the clock enable keeps being sampled
  always_comb begin
    pinSync_d = pinMeta_q; // R1
    if (!rxEnable) begin
      pinSync_d = {pinMeta_q[PIN_W-1], pinSync_q[PIN_W-2:0]}; // R5 R4
    end
  end

  always_comb begin
    cmdRaw = sdc_pkg::CMD_NOP;
    if (csS) begin
      cmdRaw = sdc_pkg::CMD_INHIBIT; // R6
    end else begin
      case ({rasS, casS, weS}) // R8
        `SDC_OP_LMR: cmdRaw = sdc_pkg::CMD_LMR;
        `SDC_OP_REF: cmdRaw = sdc_pkg::CMD_REF;
        `SDC_OP_PRE: cmdRaw = sdc_pkg::CMD_PRE;
        `SDC_OP_ACT: cmdRaw = sdc_pkg::CMD_ACT;
        `SDC_OP_WR:  cmdRaw = sdc_pkg::CMD_WRITE;
        `SDC_OP_RD:  cmdRaw = sdc_pkg::CMD_READ;
        `SDC_OP_BST: cmdRaw = sdc_pkg::CMD_BST;
        default:     cmdRaw = sdc_pkg::CMD_NOP;
      endcase
    end
    cmdLive = live ? cmdRaw : sdc_pkg::CMD_NOP;
  end

  // sequential column order only; the eight-bit column wraps from FF to 00
  always_comb begin
    state_d       = state_q;
    bankOpen_d    = bankOpen_q;
    burstAct_d    = burstAct_q;
    burstWr_d     = burstWr_q;
    burstAp_d     = burstAp_q;
    burstBank_d   = burstBank_q;
    burstCol_d    = burstCol_q;
    burstLeft_d   = burstLeft_q;
    actValid_d    = 1'b0;
    actBank_d     = actBank;
    actRow_d      = actRow;
    refValid_d    = cmdLive == sdc_pkg::CMD_REF && ckeS;
    lmrValid_d    = 1'b0;
    modeOpcode_d  = modeOpcode;
    dataOut_d     = dataOut;
    oe_d          = oe_q;
    maskD1_d      = maskD1_q;
    bankDec       = `SDC_ONE_BANK << bankS; // R12
    startRW       = cmdLive == sdc_pkg::CMD_READ || cmdLive == sdc_pkg::CMD_WRITE;
    beat          = startRW || (burstAct_q && !susp); // R7 R2
    beatWr        = startRW ? cmdLive == sdc_pkg::CMD_WRITE : burstWr_q;
    beatCol       = startRW ? addrS[`SDC_COL_W-1:0] : burstCol_q; // R15 R18
    beatAp        = startRW ? addrS[`SDC_AP_BIT] : burstAp_q; // R15
    beatBank      = startRW ? bankS : burstBank_q;
    beatLeft      = startRW ? burstLength : burstLeft_q;
    case (cmdLive)
      sdc_pkg::CMD_ACT: begin
        bankOpen_d = bankOpen_q | bankDec; // R14
        actValid_d = 1'b1;
        actBank_d  = bankS;
        actRow_d   = addrS;
      end
      sdc_pkg::CMD_PRE: begin
        bankOpen_d = addrS[`SDC_AP_BIT] ? 4'h0 : (bankOpen_q & ~bankDec); // R16
      end
      sdc_pkg::CMD_LMR: begin
        lmrValid_d   = 1'b1;
        modeOpcode_d = {bankS, addrS}; // R13
      end
      default: begin
      end
    endcase
    if (beat) begin
      burstWr_d   = beatWr;
      burstAp_d   = beatAp;
      burstBank_d = beatBank;
      if (beatLeft <= `SDC_LAST_BEAT) begin
        burstAct_d = 1'b0;
        if (beatAp) begin
          bankOpen_d = bankOpen_d & ~(`SDC_ONE_BANK << beatBank);
        end
      end else begin
        burstAct_d  = 1'b1;
        burstCol_d  = beatCol + `SDC_COL_STEP; // R2
        burstLeft_d = beatLeft - `SDC_LAST_BEAT;
      end
    end
    if (cmdLive == sdc_pkg::CMD_BST) begin
      burstAct_d = 1'b0;
    end
    // suspend holds the array port too but clears arrWrEn: the read in flight lands after wake
    arrRdEn_d     = arrRdEn;
    arrWrEn_d     = 1'b0;
    arrBank_d     = arrBank;
    arrCol_d      = arrCol;
    arrWrData_d   = arrWrData;
    arrWrByteEn_d = arrWrByteEn;
    // output stage frozen in suspend so the host sees the same word again
    if (!susp) begin
      arrRdEn_d     = beat && !beatWr;
      arrWrEn_d     = beat && beatWr;
      arrBank_d     = beatBank;
      arrCol_d      = beatCol;
      arrWrData_d   = dataS;
      arrWrByteEn_d = ~maskS; // R9 R11
      dataOut_d     = arrayRdData; // R2
      oe_d          = {4{arrRdEn}} & ~maskD1_q; // R10 R11
      maskD1_d      = maskS; // R7
    end
    case (state_q)
      sdc_pkg::PWR_RUN: begin
        if (!ckeS) begin // R3 R17
          if (burstAct_q || startRW) begin
            state_d = sdc_pkg::PWR_SUSPEND;
          end else if (cmdRaw == sdc_pkg::CMD_REF) begin
            state_d = sdc_pkg::PWR_SELF_REF;
          end else if (|bankOpen_d) begin
            state_d = sdc_pkg::PWR_ACT_DOWN;
          end else begin
            state_d = sdc_pkg::PWR_PRE_DOWN;
          end
        end
      end
      sdc_pkg::PWR_SUSPEND, sdc_pkg::PWR_ACT_DOWN, sdc_pkg::PWR_PRE_DOWN,
      sdc_pkg::PWR_SELF_REF: begin
        if (ckeS) begin
          state_d = sdc_pkg::PWR_RUN; // R4
        end
      end
      default: state_d = sdc_pkg::PWR_RUN;
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pinMeta_q   <= PIN_RST;
      pinSync_q   <= PIN_RST;
      state_q     <= sdc_pkg::PWR_PRE_DOWN;
      bankOpen_q  <= 4'h0;
      burstAct_q  <= 1'b0;
      burstWr_q   <= 1'b0;
      burstAp_q   <= 1'b0;
      burstBank_q <= 2'h0;
      burstCol_q  <= '0;
      burstLeft_q <= '0;
      actValid    <= 1'b0;
      actBank     <= 2'h0;
      actRow      <= '0;
      refValid    <= 1'b0;
      lmrValid    <= 1'b0;
      modeOpcode  <= '0;
      arrRdEn     <= 1'b0;
      arrWrEn     <= 1'b0;
      arrBank     <= 2'h0;
      arrCol      <= '0;
      arrWrData   <= 32'h0;
      arrWrByteEn <= 4'h0;
      dataOut     <= 32'h0;
      oe_q        <= 4'h0;
      maskD1_q    <= 4'h0;
    end else begin
      pinMeta_q   <= {cke, csN, rasN, casN, weN, byteMask, bankSelect, addressIn, dataIn}; // R1
      pinSync_q   <= pinSync_d;
      state_q     <= state_d;
      bankOpen_q  <= bankOpen_d;
      burstAct_q  <= burstAct_d;
      burstWr_q   <= burstWr_d;
      burstAp_q   <= burstAp_d;
      burstBank_q <= burstBank_d;
      burstCol_q  <= burstCol_d;
      burstLeft_q <= burstLeft_d;
      actValid    <= actValid_d;
      actBank     <= actBank_d;
      actRow      <= actRow_d;
      refValid    <= refValid_d;
      lmrValid    <= lmrValid_d;
      modeOpcode  <= modeOpcode_d;
      arrRdEn     <= arrRdEn_d;
      arrWrEn     <= arrWrEn_d;
      arrBank     <= arrBank_d;
      arrCol      <= arrCol_d;
      arrWrData   <= arrWrData_d;
      arrWrByteEn <= arrWrByteEn_d;
      dataOut     <= dataOut_d;
      oe_q        <= oe_d;
      maskD1_q    <= maskD1_d;
    end
  end

  for (genvar b = 0; b < 4; b++) begin : g_lane
    assign dataOe[8*b +: 8] = {8{oe_q[b]}}; // R11
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  sequence s_read_masked;
    live && ckeS && cmdRaw == sdc_pkg::CMD_READ && maskS[0] ##1 !susp;
  endsequence

  sequence s_suspended;
    susp [*2];
  endsequence

  a_cs_masks_cmd: assert property (live && csS |=> !actValid && !lmrValid && !refValid) // R6
    else $error("command taken while deselected");
  a_act_row_open: assert property (cmdLive == sdc_pkg::CMD_ACT // R14
      |=> actValid && actRow == $past(addrS) && bankOpen[actBank])
    else $error("activate row not captured");
  a_rd_start_col: assert property (cmdLive == sdc_pkg::CMD_READ // R15
      |=> arrRdEn && arrCol == $past(addrS[`SDC_COL_W-1:0]))
    else $error("read start column wrong");
  a_mask_hiz: assert property (s_read_masked |=> !dataOe[0]) // R10
    else $error("masked read byte driven");
  a_wr_mask: assert property (cmdLive == sdc_pkg::CMD_WRITE && maskS[1] // R9
      |=> arrWrEn && !arrWrByteEn[1] && arrWrByteEn[0] == !$past(maskS[0]))
    else $error("write byte mask ignored");
  a_pre_select: assert property (cmdLive == sdc_pkg::CMD_PRE && !beat // R16
      |=> bankOpen == ($past(addrS[`SDC_AP_BIT]) ? 4'h0 : ($past(bankOpen) & ~$past(bankDec))))
    else $error("precharge closed wrong banks");
  a_burst_step: assert property (burstAct_q && !susp && !startRW // R2
      && burstLeft_q > `SDC_LAST_BEAT |=> burstCol_q == 8'($past(burstCol_q) + `SDC_COL_STEP))
    else $error("burst column did not advance");
  a_deselect_run: assert property (burstAct_q && !susp && csS |=> arrRdEn || arrWrEn) // R7
    else $error("burst stopped by deselect");
  a_suspend_hold: assert property (s_suspended |-> $stable(burstCol_q) && $stable(dataOut) // R3
      && $stable(arrCol))
    else $error("state moved in clock suspend");
  a_susp_no_write: assert property (susp // R3
      |=> !arrWrEn && $stable(arrRdEn))
    else $error("array port moved in clock suspend");
  a_pd_rx_off: assert property (live && !ckeS && !burstAct_q && !startRW // R5
      |=> !rxEnable ##1 ($past(ckeS) || !rxEnable))
    else $error("receivers live in power-down");
  a_cke_wake: assert property (!live && !susp && ckeS |=> live) // R4
    else $error("no wake on clock enable");
endmodule
`default_nettype wire

// file: test/sdc_ctrl_model.sv
`default_nettype none
module sdc_ctrl_model (
  input  wire logic        core_clk,
  output logic             cke,
  output logic             csN,
  output logic             rasN,
  output logic             casN,
  output logic             weN,
  output logic [3:0]       byteMask,
  output logic [1:0]       bankSelect,
  output logic [11:0]      addressIn,
  output logic [31:0]      dataIn
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    cke = 1'h0;
    csN = 1'h1;
    {rasN, casN, weN} = 3'h7;
    byteMask = 4'h0;
    bankSelect = 2'h0;
    addressIn = 12'h0;
    dataIn = 32'h0;
  end
  // called just after a falling edge; holds the command for one full cycle
  task automatic cmd(input logic sel, input logic [2:0] op, input logic [1:0] bank,
                     input logic [11:0] addr, input logic [3:0] mask, input logic [31:0] data);
    csN = sel;
    {rasN, casN, weN} = op;
    bankSelect = bank;
    addressIn = addr;
    byteMask = mask;
    dataIn = data;
    @(negedge core_clk);
    csN = 1'h1;
    {rasN, casN, weN} = 3'h7;
    byteMask = 4'h0;
    // idle pins show the inverse so a stale value can never look valid
    bankSelect = ~bank;
    addressIn = ~addr;
    dataIn = ~data;
  endtask
  task automatic setCke(input logic v);
    cke = v;
  endtask
endmodule
`default_nettype wire

// file: test/tb_sdram_pin_command_interface.sv
`default_nettype none
`include "sdc_params.svh"
module tb_sdram_pin_command_interface;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [2:0]  op;
    logic [1:0]  bank;
    logic [11:0] addr;
    logic [3:0]  mask;
    logic [31:0] data;
    logic [31:0] exp;
  } sdc_row_s;
  logic core_clk, rst_n, cke, csN, rasN, casN, weN, rxEnable, actValid, refValid;
  logic lmrValid, arrRdEn, arrWrEn;
  logic [3:0]  byteMask, bankOpen, arrWrByteEn;
  logic [1:0]  bankSelect, actBank, arrBank;
  logic [11:0] addressIn, actRow;
  logic [31:0] dataIn, dataOut, dataOe, arrayRdData, arrWrData;
  logic [8:0]  burstLength;
  logic [13:0] modeOpcode;
  logic [7:0]  arrCol;
  sdc_pkg::sdc_pwr_e powerState;
  int fails = 0;
  int samplesChecked = 0;
  sdc_row_s rows[6] = '{
    '{`SDC_OP_REF, 2'h0, 12'h000, 4'h0, 32'h0, 32'h0},
    '{`SDC_OP_LMR, 2'h1, 12'h032, 4'h0, 32'h0, 32'h1032},
    '{`SDC_OP_ACT, 2'h2, 12'hABC, 4'h0, 32'h0, 32'hABC},
    '{`SDC_OP_ACT, 2'h1, 12'h123, 4'h0, 32'h0, 32'h123},
    '{`SDC_OP_WR, 2'h2, 12'hBA5, 4'h5, 32'h11223344, 32'hA5},
    '{`SDC_OP_WR, 2'h1, 12'h3FF, 4'hA, 32'hCAFE5A5A, 32'hFF}};
  function automatic logic [31:0] memVal(input logic [1:0] b, input logic [7:0] c);
    memVal = {6'h2A, b, c, c ^ 8'h5A, ~c};
  endfunction
  function automatic logic [31:0] lanes(input logic [3:0] m);
    lanes = {{8{m[3]}}, {8{m[2]}}, {8{m[1]}}, {8{m[0]}}};
  endfunction
  function automatic logic pick(input int k);
    case (k)
      0: pick = actValid;
      1: pick = lmrValid;
      2: pick = refValid;
      3: pick = arrWrEn;
      default: pick = arrRdEn;
    endcase
  endfunction
  assign arrayRdData = memVal(arrBank, arrCol);
  initial begin
    core_clk = 1'h0;
    forever #12.5 core_clk = ~core_clk;
  end
  sdc_ctrl_model sdc_ctrl_model_i (.core_clk(core_clk), .cke(cke), .csN(csN), .rasN(rasN),
    .casN(casN), .weN(weN), .byteMask(byteMask), .bankSelect(bankSelect),
    .addressIn(addressIn), .dataIn(dataIn));
  sdc_pin_if sdc_pin_if_i (.core_clk(core_clk), .rst_n(rst_n), .cke(cke), .csN(csN),
    .rasN(rasN), .casN(casN), .weN(weN), .byteMask(byteMask), .bankSelect(bankSelect),
    .addressIn(addressIn), .dataIn(dataIn), .dataOut(dataOut), .dataOe(dataOe),
    .burstLength(burstLength), .arrayRdData(arrayRdData), .rxEnable(rxEnable),
    .powerState(powerState), .bankOpen(bankOpen), .actValid(actValid), .actBank(actBank),
    .actRow(actRow), .refValid(refValid), .lmrValid(lmrValid), .modeOpcode(modeOpcode),
    .arrRdEn(arrRdEn), .arrWrEn(arrWrEn), .arrBank(arrBank), .arrCol(arrCol),
    .arrWrData(arrWrData), .arrWrByteEn(arrWrByteEn));
  task automatic summarize();
    $display("checked %0d mismatches %0d", samplesChecked, fails);
    if (fails == 0 && samplesChecked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    samplesChecked++;
    if (got !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask
  // a missing pulse ends the run: later checks would only cascade
  task automatic waitPulse(input int k, input logic want, input string name);
    logic seen;
    seen = 1'h0;
    for (int i = 0; i < 8 && !seen; i++) begin
      @(negedge core_clk);
      seen = (pick(k) === 1'h1);
    end
    chk(name, 32'(want), 32'(seen));
    if (want && !seen) summarize();
  endtask
  task automatic waitState(input sdc_pkg::sdc_pwr_e s);
    for (int i = 0; i < 8 && powerState !== s; i++) @(negedge core_clk);
    chk("powerState", 32'(s), 32'(powerState));
    if (powerState !== s) summarize();
  endtask
  task automatic cmd(input logic [2:0] op, input logic [1:0] b, input logic [11:0] a,
                     input logic [3:0] m);
    sdc_ctrl_model_i.cmd(1'h0, op, b, a, m, 32'h0);
  endtask
  task automatic ckeTo(input logic v, input sdc_pkg::sdc_pwr_e s);
    sdc_ctrl_model_i.setCke(v);
    waitState(s);
  endtask
  initial begin
    rst_n = 1'h0;
    burstLength = 9'h001;
    repeat (12) @(negedge core_clk);
    chk("powerState", 32'(sdc_pkg::PWR_PRE_DOWN), 32'(powerState));
    chk("rxEnable", 32'h0, 32'(rxEnable));
    rst_n = 1'h1;
    ckeTo(1'h1, sdc_pkg::PWR_RUN);
    chk("rxEnable", 32'h1, 32'(rxEnable));
    foreach (rows[i]) begin
      sdc_ctrl_model_i.cmd(1'h0, rows[i].op, rows[i].bank, rows[i].addr, rows[i].mask,
                           rows[i].data);
      case (rows[i].op)
        `SDC_OP_ACT: begin
          waitPulse(0, 1'h1, "actValid");
          chk("actBank", 32'(rows[i].bank), 32'(actBank));
          chk("actRow", rows[i].exp, 32'(actRow));
        end
        `SDC_OP_LMR: begin
          waitPulse(1, 1'h1, "lmrValid");
          chk("modeOpcode", rows[i].exp, 32'(modeOpcode));
        end
        `SDC_OP_WR: begin
          waitPulse(3, 1'h1, "arrWrEn");
          chk("arrBank", 32'(rows[i].bank), 32'(arrBank));
          chk("arrCol", rows[i].exp, 32'(arrCol));
          chk("arrWrByteEn", {28'h0, ~rows[i].mask}, 32'(arrWrByteEn));
          chk("arrWrData", rows[i].data & lanes(~rows[i].mask),
              arrWrData & lanes(~rows[i].mask));
        end
        default: waitPulse(2, 1'h1, "refValid");
      endcase
    end
    sdc_ctrl_model_i.cmd(1'h1, `SDC_OP_ACT, 2'h3, 12'h055, 4'h0, 32'h0);
    waitPulse(0, 1'h0, "actValid");
    chk("bankOpen", 32'h6, 32'(bankOpen));
    burstLength = 9'h002;
    cmd(`SDC_OP_RD, 2'h2, 12'h0FF, 4'h9);
    waitPulse(4, 1'h1, "arrRdEn");
    chk("arrCol", 32'hFF, 32'(arrCol));
    @(negedge core_clk);
    chk("arrCol", 32'h00, 32'(arrCol));
    chk("dataOe", 32'h00FFFF00, dataOe);
    chk("dataOut", memVal(2'h2, 8'hFF) & 32'h00FFFF00, dataOut & 32'h00FFFF00);
    burstLength = 9'h001;
    cmd(`SDC_OP_RD, 2'h1, 12'h410, 4'h0);
    repeat (5) @(negedge core_clk);
    chk("bankOpen", 32'h4, 32'(bankOpen));
    cmd(`SDC_OP_ACT, 2'h0, 12'h000, 4'h0);
    waitPulse(0, 1'h1, "actValid");
    cmd(`SDC_OP_PRE, 2'h0, 12'h3FF, 4'h0);
    repeat (4) @(negedge core_clk);
    chk("bankOpen", 32'h4, 32'(bankOpen));
    ckeTo(1'h0, sdc_pkg::PWR_ACT_DOWN);
    chk("rxEnable", 32'h0, 32'(rxEnable));
    cmd(`SDC_OP_ACT, 2'h3, 12'h001, 4'h0);
    ckeTo(1'h1, sdc_pkg::PWR_RUN);
    chk("bankOpen", 32'h4, 32'(bankOpen));
    cmd(`SDC_OP_PRE, 2'h1, 12'h400, 4'h0);
    repeat (4) @(negedge core_clk);
    chk("bankOpen", 32'h0, 32'(bankOpen));
    ckeTo(1'h0, sdc_pkg::PWR_PRE_DOWN);
    ckeTo(1'h1, sdc_pkg::PWR_RUN);
    sdc_ctrl_model_i.setCke(1'h0);
    cmd(`SDC_OP_REF, 2'h0, 12'h000, 4'h0);
    waitState(sdc_pkg::PWR_SELF_REF);
    ckeTo(1'h1, sdc_pkg::PWR_RUN);
    cmd(`SDC_OP_ACT, 2'h2, 12'h00F, 4'h0);
    waitPulse(0, 1'h1, "actValid");
    burstLength = 9'h008;
    cmd(`SDC_OP_RD, 2'h2, 12'h020, 4'h0);
    ckeTo(1'h0, sdc_pkg::PWR_SUSPEND);
    ckeTo(1'h1, sdc_pkg::PWR_RUN);
    // second beat was in flight when the clock stopped: it must not be lost
    chk("arrCol", 32'h21, 32'(arrCol));
    chk("dataOut", memVal(2'h2, 8'h20), dataOut);
    @(negedge core_clk);
    chk("arrCol", 32'h22, 32'(arrCol));
    chk("dataOut", memVal(2'h2, 8'h21), dataOut);
    chk("dataOe", 32'hFFFFFFFF, dataOe);
    // reset in the middle of the burst
    @(negedge core_clk);
    rst_n = 1'h0;
    @(negedge core_clk);
    chk("powerState", 32'(sdc_pkg::PWR_PRE_DOWN), 32'(powerState));
    chk("rxEnable", 32'h0, 32'(rxEnable));
    rst_n = 1'h1;
    ckeTo(1'h1, sdc_pkg::PWR_RUN);
    cmd(`SDC_OP_ACT, 2'h1, 12'h0AA, 4'h0);
    waitPulse(0, 1'h1, "actValid");
    chk("actRow", 32'h0AA, 32'(actRow));
    chk("bankOpen", 32'h2, 32'(bankOpen));
    summarize();
  end
endmodule
`default_nettype wire
